// ### ext_mem_pkg.sv
package ext_mem_pkg;
	localparam int ADDR_W        = 18;
	localparam int LOW_ADDR_W    = 15;
	localparam int DRAM_ADDR_W   = 11;
	localparam int DATA_W        = 8;
	localparam int NARROW_W      = 4;
	localparam int NUM_SEL       = 4;
	localparam int BIT15         = 15;
	localparam int BIT16         = 16;
	localparam int BIT17         = 17;
	localparam logic [14:0] LOW_ADDR_RST = 15'h7fff;
	localparam logic [3:0]  SEL_IDLE     = 4'hf;
	typedef enum logic [1:0] {
		MODE_RUN,
		MODE_SOFT_RST,
		MODE_INDIV_RST,
		MODE_STOP
	} hold_mode_e;
endpackage

// ### external_memory_pin_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module external_memory_pin_control_tb;
	import ext_mem_pkg::*;
	logic       clk, rst_b, ref_en, valid, wr, dram, col, ras, cas, nar;
	hold_mode_e mode;
	logic [17:0] addr;
	logic [1:0]  bank;
	logic [2:0]  up;
	logic [7:0]  wd, rdata, dout, oe, drv, bus;
	logic [14:0] lo;
	logic        a15, a16, a17, s0_b, wr_b, rd_b;
	int          err_count = 0;
	int          total_checks = 0;
	assign bus = (dout & oe) | (drv & ~oe);
	external_memory_port external_memory_port_inst (.i_clk(clk),
		.i_rst_b(rst_b), .i_hold_mode(mode), .i_refresh_en(ref_en),
		.i_acc_valid(valid), .i_acc_write(wr), .i_acc_dram(dram),
		.i_dram_col_phase(col), .i_dram_ras(ras), .i_dram_cas(cas),
		.i_acc_addr(addr), .i_acc_bank(bank), .i_upper_as_select(up),
		.i_narrow_bus(nar), .i_wdata(wd), .o_rdata(rdata),
		.o_mem_addr_low(lo), .o_mem_addr_bit15(a15),
		.o_mem_addr_bit16(a16), .o_mem_addr_bit17(a17),
		.o_sram_select_0_b(s0_b), .o_mem_write_strobe_b(wr_b),
		.o_mem_read_strobe_b(rd_b), .i_mem_data_bus(bus),
		.o_mem_data_bus(dout), .o_mem_data_bus_oe(oe));
	mem_chip_model mem_chip_model_inst (.i_clk(clk), .i_rd_b(rd_b),
		.i_wr_b(wr_b), .i_bus(bus), .o_drive(drv));
	////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic go(input logic w, input logic [17:0] a,
			input logic [1:0] b, input logic [7:0] d);
		@(posedge clk);
		valid <= 1'b1;
		wr <= w;
		addr <= a;
		bank <= b;
		wd <= d;
		cyc(2);
	endtask
	task automatic halt();
		@(posedge clk);
		valid <= 1'b0;
		cyc(2);
		chk({s0_b, wr_b, rd_b, oe}, {3'b111, 8'h00});
	endtask
	task automatic set_mode(input hold_mode_e m, input logic r);
		@(posedge clk);
		mode <= m;
		ref_en <= r;
		cyc(2);
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic t_sram_write();
		go(1'b1, 18'h2a5c3, 2'd0, 8'h96);
		chk({a17, a16, a15, lo}, 18'h2a5c3);
		chk({s0_b, wr_b, rd_b}, 3'b001);
		chk({oe, dout}, 16'hff96);
		halt();
		go(1'b0, 18'h2a5c3, 2'd0, 8'h00);
		cyc(4);
		chk(rdata, 8'h96);
		halt();
	endtask
	task automatic t_banks();
		@(posedge clk);
		up <= 3'b111;
		nar <= 1'b1;
		for (int b = 0; b < 4; b++) begin
			go(1'b0, 18'h00011, b[1:0], 8'h00);
			chk({a15, a16, a17, s0_b}, 4'hf ^ (4'h1 << b));
			chk({rd_b, wr_b, oe}, 10'h100);
			cyc(4);
			chk(rdata, 8'h06);
			halt();
		end
		go(1'b1, 18'h00011, 2'd0, 8'h3c);
		chk({oe, dout[3:0]}, 12'h0fc);
		halt();
		@(posedge clk);
		up <= 3'b000;
		nar <= 1'b0;
	endtask
	task automatic t_dram();
		@(posedge clk);
		dram <= 1'b1;
		ras <= 1'b0;
		go(1'b0, 18'h3f5a5, 2'd0, 8'h00);
		chk(lo, 15'h05a5);
		chk({a17, a16, rd_b}, 3'b010);
		@(posedge clk);
		cas <= 1'b0;
		col <= 1'b1;
		cyc(2);
		chk({a16, lo}, 16'h007e);
		halt();
		@(posedge clk);
		{ras, cas} <= 2'b11;
		{dram, col} <= 2'b00;
	endtask
	task automatic t_hw_reset();
		go(1'b1, 18'h0a0a0, 2'd0, 8'h5a);
		@(posedge clk);
		rst_b <= 1'b0;
		cyc(1);
		chk({a17, a16, a15, lo, s0_b, wr_b, rd_b, oe}, 29'h1fffff00);
		chk({oe, dout}, 16'h0000);
		@(posedge clk);
		valid <= 1'b0;
		rst_b <= 1'b1;
		cyc(2);
		chk({a17, a16, a15, lo, s0_b, wr_b, rd_b, oe}, 29'h1fffff00);
	endtask
	task automatic t_hold();
		go(1'b0, 18'h15555, 2'd0, 8'h00);
		set_mode(MODE_INDIV_RST, 1'b0);
		chk({a17, a16, a15, lo, s0_b, rd_b}, 20'h55557);
		set_mode(MODE_INDIV_RST, 1'b1);
		chk({a17, a16, s0_b, wr_b, rd_b}, 5'h07);
		set_mode(MODE_RUN, 1'b0);
		set_mode(MODE_STOP, 1'b1);
		chk({a17, a16, a15, lo, s0_b, rd_b}, 20'h55557);
		set_mode(MODE_SOFT_RST, 1'b0);
		chk({a17, a16, a15, lo, s0_b, rd_b}, 20'hf5557);
		set_mode(MODE_RUN, 1'b0);
		halt();
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		#4000;
		err_count++;
		final_report();
	end
	initial begin
		{rst_b, ref_en, valid, wr, dram, col, nar, bank, up, addr} = '0;
		{ras, cas} = 2'b11;
		mode = MODE_RUN;
		wd = 8'h00;
		cyc(6);
		chk({a17, a16, a15, lo, s0_b, wr_b, rd_b, oe}, 29'h1ffff_f00);
		@(posedge clk);
		rst_b <= 1'b1;
		t_sram_write();
		t_banks();
		t_dram();
		t_hold();
		t_hw_reset();
		final_report();
	end
endmodule
`default_nettype wire

// ### external_memory_port.sv
`timescale 1ns/1ns
`default_nettype none
module external_memory_port (
	input  wire logic                         i_clk,
	input  wire logic                         i_rst_b,
	input  wire ext_mem_pkg::hold_mode_e      i_hold_mode,
	input  wire logic                         i_refresh_en,
	input  wire logic                         i_acc_valid,
	input  wire logic                         i_acc_write,
	input  wire logic                         i_acc_dram,
	input  wire logic                         i_dram_col_phase,
	input  wire logic                         i_dram_ras,
	input  wire logic                         i_dram_cas,
	input  wire logic [ext_mem_pkg::ADDR_W-1:0] i_acc_addr,
	input  wire logic [1:0]                   i_acc_bank,
	input  wire logic [2:0]                   i_upper_as_select,
	input  wire logic                         i_narrow_bus,
	input  wire logic [ext_mem_pkg::DATA_W-1:0] i_wdata,
	output logic      [ext_mem_pkg::DATA_W-1:0] o_rdata,
	output logic      [ext_mem_pkg::LOW_ADDR_W-1:0] o_mem_addr_low,
	output logic                              o_mem_addr_bit15,
	output logic                              o_mem_addr_bit16,
	output logic                              o_mem_addr_bit17,
	output logic                              o_sram_select_0_b,
	output logic                              o_mem_write_strobe_b,
	output logic                              o_mem_read_strobe_b,
	input  wire logic [ext_mem_pkg::DATA_W-1:0] i_mem_data_bus,
	output logic      [ext_mem_pkg::DATA_W-1:0] o_mem_data_bus,
	output logic      [ext_mem_pkg::DATA_W-1:0] o_mem_data_bus_oe
);
	import ext_mem_pkg::*;

	logic [NUM_SEL-1:0] sel_b;
	logic               sram_acc;
	logic               run;
	logic [DATA_W-1:0]  din_meta_reg;
	logic [DATA_W-1:0]  din_sync_reg;
	logic [DRAM_ADDR_W-1:0] dram_row;
	logic [DRAM_ADDR_W-1:0] dram_col;

	// column is the address bits above the row, zero filled;
	// only seven of them exist, so the top column lines stay low
	assign dram_row = i_acc_addr[DRAM_ADDR_W-1:0];
	assign dram_col = DRAM_ADDR_W'(i_acc_addr[ADDR_W-1:DRAM_ADDR_W]);

	assign run      = (i_hold_mode == MODE_RUN);
	assign sram_acc = run && i_acc_valid && !i_acc_dram;

	sram_select_decode #(
		.NUM_SEL (NUM_SEL)
	) u_sel (
		.i_en    (sram_acc),
		.i_bank  (i_acc_bank),
		.o_sel_b (sel_b)
	);

	////////////////////////////////////////////////////////////////////////
	// address lines; reset values are all ones
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_mem_addr_low <= LOW_ADDR_RST;
		end else if (run && i_acc_valid) begin
			if (i_acc_dram) begin
				// row then column on the low lines only
				o_mem_addr_low <= LOW_ADDR_W'(i_dram_col_phase ?
				    dram_col : dram_row);
			end else begin
				o_mem_addr_low <= i_acc_addr[LOW_ADDR_W-1:0];
			end
		end
		// soft, individual reset and stop keep the low lines
	end

	// shared upper pins
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_mem_addr_bit15 <= 1'b1;
			o_mem_addr_bit16 <= 1'b1;
			o_mem_addr_bit17 <= 1'b1;
		end else if (i_hold_mode == MODE_SOFT_RST) begin
			o_mem_addr_bit15 <= 1'b1;
			o_mem_addr_bit16 <= 1'b1;
			o_mem_addr_bit17 <= 1'b1;
		end else if (!run) begin
			// previous state unless pin acts as select or strobe
			if (i_upper_as_select[0])
				o_mem_addr_bit15 <= 1'b1;
			if (i_upper_as_select[1])
				o_mem_addr_bit16 <= 1'b1;
			if (i_upper_as_select[2])
				o_mem_addr_bit17 <= 1'b1;
			if (i_hold_mode == MODE_INDIV_RST && i_refresh_en) begin
				o_mem_addr_bit16 <= 1'b0;
				o_mem_addr_bit17 <= 1'b0;
			end
		end else if (i_acc_valid && i_acc_dram) begin
			o_mem_addr_bit16 <= i_dram_cas;
			o_mem_addr_bit17 <= i_dram_ras;
			if (i_upper_as_select[0])
				o_mem_addr_bit15 <= 1'b1;
		end else if (i_acc_valid) begin
			o_mem_addr_bit15 <= i_upper_as_select[0] ? sel_b[3] :
			    i_acc_addr[BIT15];
			o_mem_addr_bit16 <= i_upper_as_select[1] ? sel_b[2] :
			    i_acc_addr[BIT16];
			o_mem_addr_bit17 <= i_upper_as_select[2] ? sel_b[1] :
			    i_acc_addr[BIT17];
		end else begin
			// idle: pins used as selects release high, the others keep their value
			if (i_upper_as_select[0])
				o_mem_addr_bit15 <= 1'b1;
			if (i_upper_as_select[1])
				o_mem_addr_bit16 <= 1'b1;
			if (i_upper_as_select[2])
				o_mem_addr_bit17 <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// select 0 and strobes
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_sram_select_0_b    <= 1'b1;
			o_mem_write_strobe_b <= 1'b1;
			o_mem_read_strobe_b  <= 1'b1;
		end else begin
			o_sram_select_0_b    <= sel_b[0];
			o_mem_write_strobe_b <= !(run && i_acc_valid && i_acc_write);
			o_mem_read_strobe_b  <= !(run && i_acc_valid && !i_acc_write);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// data bus; narrow mode never enables upper lanes
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_mem_data_bus    <= '0;
			o_mem_data_bus_oe <= '0;
		end else begin
			o_mem_data_bus <= i_wdata;
			if (run && i_acc_valid && i_acc_write)
				o_mem_data_bus_oe <= i_narrow_bus ? 8'h0f : 8'hff;
			else
				o_mem_data_bus_oe <= '0;
		end
	end

	// pins come from outside the clock domain
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			din_meta_reg <= '0;
			din_sync_reg <= '0;
			o_rdata      <= '0;
		end else begin
			din_meta_reg <= i_mem_data_bus;
			din_sync_reg <= din_meta_reg;
			o_rdata      <= i_narrow_bus ?
			    {4'h0, din_sync_reg[NARROW_W-1:0]} : din_sync_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	property p_write_strobe;
		@(posedge i_clk) disable iff (!i_rst_b)
		(run && i_acc_valid && i_acc_write) |=> !o_mem_write_strobe_b;
	endproperty
	a_write_strobe: assert property (p_write_strobe)
		else $error("write strobe missing");

	property p_read_strobe;
		@(posedge i_clk) disable iff (!i_rst_b)
		!(run && i_acc_valid && !i_acc_write) |=> o_mem_read_strobe_b;
	endproperty
	a_read_strobe: assert property (p_read_strobe)
		else $error("stray read strobe");

	property p_bus_idle;
		@(posedge i_clk) disable iff (!i_rst_b)
		!(run && i_acc_valid && i_acc_write) |=> o_mem_data_bus_oe == 8'h00;
	endproperty
	a_bus_idle: assert property (p_bus_idle)
		else $error("bus driven while idle");

	property p_narrow;
		@(posedge i_clk) disable iff (!i_rst_b)
		i_narrow_bus |=> o_mem_data_bus_oe[7:4] == 4'h0;
	endproperty
	a_narrow: assert property (p_narrow)
		else $error("upper lanes driven");

	property p_one_select;
		@(posedge i_clk) disable iff (!i_rst_b)
		$countones(~sel_b) <= 1;
	endproperty
	a_one_select: assert property (p_one_select)
		else $error("two selects");

	property p_hold_low;
		@(posedge i_clk) disable iff (!i_rst_b)
		!run |=> $stable(o_mem_addr_low);
	endproperty
	a_hold_low: assert property (p_hold_low)
		else $error("low address moved");

	property p_soft_high;
		@(posedge i_clk) disable iff (!i_rst_b)
		i_hold_mode == MODE_SOFT_RST |=> o_mem_addr_bit15 && o_mem_addr_bit16
		    && o_mem_addr_bit17 && o_sram_select_0_b && o_mem_read_strobe_b;
	endproperty
	a_soft_high: assert property (p_soft_high)
		else $error("soft reset not high");

	property p_refresh_low;
		@(posedge i_clk) disable iff (!i_rst_b)
		(i_hold_mode == MODE_INDIV_RST && i_refresh_en) |=>
		    !o_mem_addr_bit16 && !o_mem_addr_bit17;
	endproperty
	a_refresh_low: assert property (p_refresh_low)
		else $error("refresh strobes high");

	property p_dram_addr;
		@(posedge i_clk) disable iff (!i_rst_b)
		(run && i_acc_valid && i_acc_dram) |=> o_mem_addr_low[14:11] == 4'h0;
	endproperty
	a_dram_addr: assert property (p_dram_addr)
		else $error("dram used high lines");
endmodule
`default_nettype wire

// ### mem_chip_model.sv
`timescale 1ns/1ns
`default_nettype none
module mem_chip_model (
	input  wire logic       i_clk,
	input  wire logic       i_rd_b,
	input  wire logic       i_wr_b,
	input  wire logic [7:0] i_bus,
	output logic      [7:0] o_drive
);
	logic [7:0] mem_reg = 8'h00;
	logic [7:0] last_reg = 8'h00;
	////////////////////////////////////////////////////////////////////
	// one cell only; address decoding is judged at the pins
	always @(posedge i_clk) begin
		if (!i_wr_b) begin
			mem_reg <= i_bus;
		end
		if (!i_rd_b) begin
			last_reg <= mem_reg;
		end
	end
	// released bus flips so stale data never looks right
	assign o_drive = !i_rd_b ? mem_reg : ~last_reg;
endmodule
`default_nettype wire

// ### sram_select_decode.sv
`timescale 1ns/1ns
`default_nettype none
module sram_select_decode #(
	parameter int NUM_SEL = 4
) (
	input  wire logic               i_en,
	input  wire logic [1:0]         i_bank,
	output logic      [NUM_SEL-1:0] o_sel_b
);
	// one-hot active low, at most one low per access
	genvar g;
	generate
		for (g = 0; g < NUM_SEL; g++) begin : g_sel
			assign o_sel_b[g] = !(i_en && (i_bank == 2'(g)));
		end
	endgenerate
endmodule
`default_nettype wire
